//--- rtl/flash_auto_operation_status.sv
// flash command sequencer with data-polling and toggle status reads
`timescale 1ns/10ps
module flash_auto_operation_status
	import flash_seq_pkg::*;
#(
	parameter int                MEM_AW          = 14,
	parameter logic [BUS_AW-1:0] FLASH_BASE      = 24'hfe0000,
	parameter logic [BUS_AW-1:0] FLASH_BOOT_BASE = 24'h010000,
	parameter logic [BUS_AW-1:0] BOOT_ROM_BASE   = 24'hff0000,
	parameter int                SECTOR_CYC      = SECTOR_CYCLES,
	parameter int                CHIP_CYC        = CHIP_CYCLES
) (
	// clock and reset
	input  wire logic                      I_SYS_CLK,
	input  wire logic                      I_RST_N,
	// mode
	input  wire logic                      I_SINGLE_BOOT,
	// cpu bus
	input  wire flash_seq_pkg::bus_req_t   I_BUS_REQ,
	output logic                           O_BUS_RVALID,
	output logic [flash_seq_pkg::BUS_DW-1:0] O_BUS_RDATA,
	// status
	output flash_seq_pkg::flash_stat_t     O_STAT
);

	import flash_seq_pkg::*;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [BUS_AW-1:0]    base_now;
	logic                 hit;
	logic                 wr;
	logic                 rd;
	logic [CMD_OFS_W-1:0] ofs;
	logic [7:0]           cmd;
	logic [MEM_AW-1:0]    waddr;

	assign base_now = I_SINGLE_BOOT ? FLASH_BOOT_BASE : FLASH_BASE;
	assign hit      = I_BUS_REQ.valid && (I_BUS_REQ.addr[BUS_AW-1:MEM_AW+1] == base_now[BUS_AW-1:MEM_AW+1]);
	assign wr       = hit && I_BUS_REQ.write;
	assign rd       = hit && !I_BUS_REQ.write;
	assign ofs      = I_BUS_REQ.addr[CMD_OFS_W-1:0];
	assign cmd      = I_BUS_REQ.wdata[7:0];
	assign waddr    = I_BUS_REQ.addr[MEM_AW:1];

	// ----------------------------------------------------------------
	// command sequence
	// ----------------------------------------------------------------
	seq_state_t        state_reg;
	seq_state_t        state_next;
	op_kind_t          op_reg;
	op_kind_t          op_next;
	logic              start;
	logic              finish;
	logic [TIMER_W-1:0] timer_reg;
	logic [MEM_AW-1:0] walk_reg;
	logic              walk_done_reg;

	always_comb begin
		state_next = state_reg;
		op_next    = op_reg;
		start      = 1'b0;
		if (state_reg == ST_BUSY) begin
			if (finish) begin
				state_next = ST_READ;
			end
		end else if (wr) begin
			state_next = ST_READ;
			unique case (state_reg)
				ST_READ: begin
					if (ofs == CMD_OFS_A && cmd == CMD_UNLOCK_A) state_next = ST_UNLOCK1;
				end
				ST_UNLOCK1: begin
					if (ofs == CMD_OFS_B && cmd == CMD_UNLOCK_B) state_next = ST_UNLOCK2;
				end
				ST_UNLOCK2: begin
					if (ofs == CMD_OFS_A && cmd == CMD_PROGRAM) state_next = ST_PROG_DATA;
					if (ofs == CMD_OFS_A && cmd == CMD_ERASE) state_next = ST_ERASE_UNLK0;
					if (ofs == CMD_OFS_A && cmd == CMD_PROTECT) state_next = ST_PROT_ADDR;
				end
				ST_PROG_DATA: begin
					state_next = ST_BUSY;
					op_next    = OP_PROG;
					start      = 1'b1;
				end
				ST_ERASE_UNLK0: begin
					if (ofs == CMD_OFS_A && cmd == CMD_UNLOCK_A) state_next = ST_ERASE_UNLK1;
				end
				ST_ERASE_UNLK1: begin
					if (ofs == CMD_OFS_B && cmd == CMD_UNLOCK_B) state_next = ST_ERASE_CMD;
				end
				ST_ERASE_CMD: begin
					if (cmd == CMD_SECTOR) begin
						state_next = ST_BUSY;
						op_next    = OP_SECTOR;
						start      = 1'b1;
					end else if (ofs == CMD_OFS_A && cmd == CMD_CHIP) begin
						state_next = ST_BUSY;
						op_next    = OP_CHIP;
						start      = 1'b1;
					end
				end
				ST_PROT_ADDR: begin
					if (ofs == PROT_OFS) begin
						state_next = ST_BUSY;
						op_next    = OP_PROT;
						start      = 1'b1;
					end
				end
				default: state_next = ST_READ;
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_reg <= ST_READ;
			op_reg    <= OP_PROG;
		end else begin
			state_reg <= state_next;
			op_reg    <= op_next;
		end
	end

	// ----------------------------------------------------------------
	// operation latch, timer and erase walker
	// ----------------------------------------------------------------
	logic [MEM_AW-1:0] prog_addr_reg;
	logic [BUS_DW-1:0] prog_value_reg;
	logic [7:0]        prot_code_reg;
	logic              walk_last;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			prog_addr_reg  <= '0;
			prog_value_reg <= '0;
			prot_code_reg  <= '0;
		end else if (start) begin
			prog_addr_reg  <= waddr;
			prog_value_reg <= I_BUS_REQ.wdata;
			prot_code_reg  <= cmd;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			timer_reg <= '0;
		end else if (start) begin
			unique case (op_next)
				OP_SECTOR: timer_reg <= TIMER_W'(SECTOR_CYC - 1);
				OP_CHIP:   timer_reg <= TIMER_W'(CHIP_CYC - 1);
				OP_PROG,
				OP_PROT:   timer_reg <= TIMER_W'(PROG_CYCLES - 1);
			endcase
		end else if (state_reg == ST_BUSY && timer_reg != '0) begin
			timer_reg <= timer_reg - 1'b1;
		end
	end

	assign walk_last = (op_reg == OP_CHIP) ? (&walk_reg) : (&walk_reg[SECTOR_AW-1:0]);
	assign finish    = (state_reg == ST_BUSY) && (timer_reg == '0) && walk_done_reg;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			walk_reg      <= '0;
			walk_done_reg <= 1'b0;
		end else if (start) begin
			walk_reg      <= (op_next == OP_CHIP) ? '0 : {waddr[MEM_AW-1:SECTOR_AW], {SECTOR_AW{1'b0}}};
			walk_done_reg <= (op_next == OP_PROG) || (op_next == OP_PROT);
		end else if (state_reg == ST_BUSY && !walk_done_reg) begin
			walk_reg      <= walk_reg + 1'b1;
			walk_done_reg <= walk_last;
		end
	end

	// ----------------------------------------------------------------
	// protection flags
	// ----------------------------------------------------------------
	logic read_prot_reg;
	logic write_prot_reg;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			read_prot_reg  <= 1'b0;
			write_prot_reg <= 1'b0;
		end else if (finish && op_reg == OP_CHIP) begin
			read_prot_reg  <= 1'b0;
			write_prot_reg <= 1'b0;
		end else if (finish && op_reg == OP_PROT) begin
			if (prot_code_reg != PROT_WRITE_ONLY) read_prot_reg <= 1'b1;
			if (prot_code_reg != PROT_READ_ONLY) write_prot_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// toggle bit and settle window
	// ----------------------------------------------------------------
	logic                toggle_reg;
	logic [SETTLE_W-1:0] settle_reg;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			toggle_reg <= 1'b1;
		end else if (start) begin
			toggle_reg <= 1'b1;
		end else if (rd && state_reg == ST_BUSY) begin
			toggle_reg <= ~toggle_reg;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			settle_reg <= '0;
		end else if (finish) begin
			settle_reg <= SETTLE_W'(SETTLE_CYCLES);
		end else if (settle_reg != '0) begin
			settle_reg <= settle_reg - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// cell array port
	// ----------------------------------------------------------------
	logic              mem_en;
	logic              mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [BUS_DW-1:0] mem_wdata;
	logic [BUS_DW-1:0] mem_rdata;

	always_comb begin
		mem_en    = 1'b0;
		mem_we    = 1'b0;
		mem_addr  = waddr;
		mem_wdata = ERASED_WORD;
		if (state_reg == ST_BUSY && !walk_done_reg) begin
			mem_en   = 1'b1;
			mem_we   = 1'b1;
			mem_addr = walk_reg;
		end else if (finish && op_reg == OP_PROG) begin
			mem_en    = 1'b1;
			mem_we    = 1'b1;
			mem_addr  = prog_addr_reg;
			mem_wdata = prog_value_reg;
		end else if (rd && state_reg != ST_BUSY) begin
			mem_en = 1'b1;
		end
	end

	flash_cell_array #(
		.AW (MEM_AW),
		.DW (BUS_DW)
	) u_cells (
		.clk   (I_SYS_CLK),
		.en    (mem_en),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	// ----------------------------------------------------------------
	// read return, two cycles after the request
	// ----------------------------------------------------------------
	logic              rd1_reg;
	logic              rd1_stat_reg;
	logic              rd1_settle_reg;
	logic              rd1_byte_reg;
	logic              rd1_hi_reg;
	logic [BUS_DW-1:0] rd1_word_reg;
	logic [BUS_DW-1:0] stat_word;
	logic [BUS_DW-1:0] cell_word;
	logic [BUS_DW-1:0] rdata_reg;
	logic              rvalid_reg;
	logic [1:0]        poll;

	always_comb begin
		unique case (op_reg)
			OP_PROG: poll = ~{prog_value_reg[15], prog_value_reg[7]};
			OP_SECTOR,
			OP_CHIP: poll = 2'h0;
			OP_PROT: poll = 2'h0;
		endcase
	end

	assign stat_word = {poll[1], toggle_reg, 6'h00, poll[0], toggle_reg, 6'h00};
	assign cell_word = rd1_settle_reg ? (mem_rdata & 16'h8080) | {1'b0, toggle_reg, 7'h00, toggle_reg, 6'h00}
	                                  : mem_rdata;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rd1_reg        <= 1'b0;
			rd1_stat_reg   <= 1'b0;
			rd1_settle_reg <= 1'b0;
			rd1_byte_reg   <= 1'b0;
			rd1_hi_reg     <= 1'b0;
			rd1_word_reg   <= '0;
		end else begin
			rd1_reg        <= rd;
			rd1_stat_reg   <= state_reg == ST_BUSY;
			rd1_settle_reg <= settle_reg != '0;
			rd1_byte_reg   <= I_BUS_REQ.byte_sel;
			rd1_hi_reg     <= I_BUS_REQ.addr[0];
			rd1_word_reg   <= stat_word;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
		end else begin
			rvalid_reg <= rd1_reg;
			if (rd1_reg) begin
				if (rd1_stat_reg && rd1_byte_reg) begin
					rdata_reg <= {8'h00, rd1_word_reg[7:0]};
				end else if (rd1_stat_reg) begin
					rdata_reg <= rd1_word_reg;
				end else if (rd1_byte_reg) begin
					rdata_reg <= {8'h00, rd1_hi_reg ? cell_word[15:8] : cell_word[7:0]};
				end else begin
					rdata_reg <= cell_word;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign O_BUS_RVALID         = rvalid_reg;
	assign O_BUS_RDATA          = rdata_reg;
	assign O_STAT.busy          = state_reg == ST_BUSY;
	assign O_STAT.settling      = settle_reg != '0;
	assign O_STAT.read_protect  = read_prot_reg;
	assign O_STAT.write_protect = write_prot_reg;
	assign O_STAT.boot_rom_sel  = I_SINGLE_BOOT && I_BUS_REQ.valid && (I_BUS_REQ.addr >= BOOT_ROM_BASE);

endmodule

//--- rtl/flash_seq_pkg.sv
// shared constants and types of the flash auto-operation sequencer
package flash_seq_pkg;

	// ----------------------------------------------------------------
	// bus shape
	// ----------------------------------------------------------------
	localparam int BUS_AW    = 24;
	localparam int BUS_DW    = 16;
	localparam int CMD_OFS_W = 12;
	localparam int SECTOR_AW = 12;

	// ----------------------------------------------------------------
	// command offsets and codes
	// ----------------------------------------------------------------
	localparam logic [CMD_OFS_W-1:0] CMD_OFS_A = 12'haaa;
	localparam logic [CMD_OFS_W-1:0] CMD_OFS_B = 12'h554;
	localparam logic [CMD_OFS_W-1:0] PROT_OFS  = 12'h77e;

	localparam logic [7:0] CMD_UNLOCK_A    = 8'haa;
	localparam logic [7:0] CMD_UNLOCK_B    = 8'h55;
	localparam logic [7:0] CMD_PROGRAM     = 8'ha0;
	localparam logic [7:0] CMD_ERASE       = 8'h80;
	localparam logic [7:0] CMD_SECTOR      = 8'h30;
	localparam logic [7:0] CMD_CHIP        = 8'h10;
	localparam logic [7:0] CMD_PROTECT     = 8'ha5;
	localparam logic [7:0] PROT_READ_ONLY  = 8'hf0;
	localparam logic [7:0] PROT_WRITE_ONLY = 8'h0f;

	localparam logic [BUS_DW-1:0] ERASED_WORD = 16'hffff;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 50;
	localparam int PROG_TIME_NS   = 60000;
	localparam int SECTOR_TIME_NS = 75000000;
	localparam int CHIP_TIME_NS   = 300000000;
	localparam int SETTLE_TIME_NS = 1000;
	localparam int PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int SECTOR_CYCLES  = SECTOR_TIME_NS / CLK_PERIOD_NS;
	localparam int CHIP_CYCLES    = CHIP_TIME_NS / CLK_PERIOD_NS;
	localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W        = 23;
	localparam int SETTLE_W       = 5;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_READ        = 4'h0,
		ST_UNLOCK1     = 4'h1,
		ST_UNLOCK2     = 4'h2,
		ST_PROG_DATA   = 4'h3,
		ST_ERASE_UNLK0 = 4'h4,
		ST_ERASE_UNLK1 = 4'h5,
		ST_ERASE_CMD   = 4'h6,
		ST_PROT_ADDR   = 4'h7,
		ST_BUSY        = 4'h8
	} seq_state_t;

	typedef enum logic [1:0] {
		OP_PROG   = 2'h0,
		OP_SECTOR = 2'h1,
		OP_CHIP   = 2'h2,
		OP_PROT   = 2'h3
	} op_kind_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic              byte_sel;
		logic [BUS_AW-1:0] addr;
		logic [BUS_DW-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic busy;
		logic settling;
		logic read_protect;
		logic write_protect;
		logic boot_rom_sel;
	} flash_stat_t;

endpackage

//--- rtl/flash_cell_array.sv
// single-port cell array with registered read data
`timescale 1ns/10ps
module flash_cell_array #(
	parameter int AW = 14,
	parameter int DW = 16
) (
	// clock
	input  wire logic          clk,
	// access
	input  wire logic          en,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] cells [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (en) begin
			if (we) begin
				cells[addr] <= wdata;
			end else begin
				rdata <= cells[addr];
			end
		end
	end

endmodule

//--- sim/flash_seq_monitor.sv
// port checker for the flash sequencer
`timescale 1ns/10ps
module flash_seq_monitor
	import flash_seq_pkg::*;
#(
	parameter int                MEM_AW          = 14,
	parameter logic [BUS_AW-1:0] FLASH_BASE      = 24'hfe0000,
	parameter logic [BUS_AW-1:0] FLASH_BOOT_BASE = 24'h010000,
	parameter logic [BUS_AW-1:0] BOOT_ROM_BASE   = 24'hff0000,
	parameter int                SECTOR_CYC      = 5000,
	parameter int                CHIP_CYC        = 20000
) (
	// clock and reset
	input  wire logic                             I_SYS_CLK,
	input  wire logic                             I_RST_N,
	// watched ports
	input  wire logic                             I_SINGLE_BOOT,
	input  wire flash_seq_pkg::bus_req_t          I_BUS_REQ,
	input  wire logic                             O_BUS_RVALID,
	input  wire logic [flash_seq_pkg::BUS_DW-1:0] O_BUS_RDATA,
	input  wire flash_seq_pkg::flash_stat_t       O_STAT
);
	logic [BUS_AW-1:0] base;
	logic              rd_hit;
	logic [1:0]        pend;
	logic              busy_q;
	logic              tg_seen;
	logic              tg_last;
	int                bcnt;
	int                scnt;

	assign base   = I_SINGLE_BOOT ? FLASH_BOOT_BASE : FLASH_BASE;
	assign rd_hit = I_BUS_REQ.valid && !I_BUS_REQ.write && (I_BUS_REQ.addr[BUS_AW-1:MEM_AW+1] == base[BUS_AW-1:MEM_AW+1]);

	// status reads in flight and cycle counts
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pend    <= '0;
			busy_q  <= 1'b0;
			tg_seen <= 1'b0;
			tg_last <= 1'b0;
			bcnt    <= 0;
			scnt    <= 0;
		end else begin
			pend   <= {pend[0], rd_hit && O_STAT.busy};
			busy_q <= O_STAT.busy;
			bcnt   <= O_STAT.busy ? bcnt + 1 : 0;
			scnt   <= O_STAT.settling ? scnt + 1 : 0;
			if (O_STAT.busy && !busy_q) begin
				tg_seen <= 1'b0;
			end else if (O_BUS_RVALID && pend[1]) begin
				tg_seen <= 1'b1;
				tg_last <= O_BUS_RDATA[6];
			end
		end
	end

	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_rd_ans;
		rd_hit |-> ##2 O_BUS_RVALID;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered after two cycles");
	property p_rd_cause;
		O_BUS_RVALID |-> $past(rd_hit, 2);
	endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("answer without a read");
	property p_rdata_hold;
		!O_BUS_RVALID |-> $stable(O_BUS_RDATA);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without answer");
	property p_tog_first;
		O_BUS_RVALID && pend[1] && !tg_seen |-> O_BUS_RDATA[6];
	endproperty
	a_tog_first: assert property (p_tog_first) else $error("first toggle read not one");
	property p_tog_alt;
		O_BUS_RVALID && pend[1] && tg_seen |-> O_BUS_RDATA[6] != tg_last;
	endproperty
	a_tog_alt: assert property (p_tog_alt) else $error("toggle bit did not invert");
	property p_busy_len;
		$fell(O_STAT.busy) |-> bcnt inside {PROG_CYCLES, SECTOR_CYC, CHIP_CYC};
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("operation length wrong");
	property p_settle_start;
		$fell(O_STAT.busy) |-> ##[0:1] O_STAT.settling;
	endproperty
	a_settle_start: assert property (p_settle_start) else $error("no settle window after operation");
	property p_settle_len;
		$fell(O_STAT.settling) |-> scnt == SETTLE_CYCLES;
	endproperty
	a_settle_len: assert property (p_settle_len) else $error("settle window length wrong");
	property p_busy_cause;
		$rose(O_STAT.busy) |-> $past(I_BUS_REQ.valid && I_BUS_REQ.write);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("operation started without a write");
	property p_boot_sel;
		O_STAT.boot_rom_sel == (I_SINGLE_BOOT && I_BUS_REQ.valid && I_BUS_REQ.addr >= BOOT_ROM_BASE);
	endproperty
	a_boot_sel: assert property (p_boot_sel) else $error("boot rom select wrong");

	c_prog: cover property ($fell(O_STAT.busy) && bcnt == PROG_CYCLES);
	c_chip: cover property ($fell(O_STAT.busy) && bcnt == CHIP_CYC);
	c_tog: cover property (O_BUS_RVALID && pend[1] && tg_seen);
endmodule

bind flash_auto_operation_status flash_seq_monitor #(
	.MEM_AW(MEM_AW),
	.FLASH_BASE(FLASH_BASE),
	.FLASH_BOOT_BASE(FLASH_BOOT_BASE),
	.BOOT_ROM_BASE(BOOT_ROM_BASE),
	.SECTOR_CYC(SECTOR_CYC),
	.CHIP_CYC(CHIP_CYC)
) i_flash_seq_monitor (.I_SYS_CLK, .I_RST_N, .I_SINGLE_BOOT, .I_BUS_REQ, .O_BUS_RVALID, .O_BUS_RDATA, .O_STAT);

//--- sim/flash_cpu_model.sv
// cpu bus master running the flash routine from ram
`timescale 1ns/10ps
module flash_cpu_model
	import flash_seq_pkg::*;
(
	// clock
	input  wire logic                             clk,
	// bus
	output flash_seq_pkg::bus_req_t               req,
	input  wire logic                             rvalid,
	input  wire logic [flash_seq_pkg::BUS_DW-1:0] rdata
);
	int poll_fail = 0;

	initial req = '0;

	// one access; no fetch from flash, no interrupt between cycles
	task automatic access(input logic w, input logic b, input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
		@(posedge clk);
		req <= '{valid: 1'b1, write: w, byte_sel: b, addr: a, wdata: d};
		@(posedge clk);
		req <= '{valid: 1'b0, write: ~w, byte_sel: ~b, addr: ~a, wdata: ~d};
	endtask

	task automatic wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
		access(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [BUS_AW-1:0] a, input logic b, output logic [BUS_DW-1:0] q);
		access(1'b0, b, a, '0);
		q = 'x;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			if (rvalid === 1'b1) begin
				q = rdata;
				break;
			end
		end
	endtask

	// reread one address until two reads agree, bounded
	task automatic poll(input logic [BUS_AW-1:0] a, input int lim, output logic [BUS_DW-1:0] q);
		logic [BUS_DW-1:0] prev;
		int                n;
		rd(a, 1'b0, prev);
		for (n = 0; n < lim; n++) begin
			rd(a, 1'b0, q);
			if (q === prev)
				break;
			prev = q;
		end
		if (n == lim)
			poll_fail++;
	endtask
endmodule

//--- sim/tb.sv
// self-checking bench of the flash sequencer
`timescale 1ns/10ps
module tb;
	import flash_seq_pkg::*;

	localparam logic [BUS_AW-1:0] BASE = 24'hfe0000;

	logic              clk;
	logic              rst_n;
	logic              single_boot;
	bus_req_t          req;
	logic              rvalid;
	logic [BUS_DW-1:0] rdata;
	flash_stat_t       stat;
	logic [BUS_DW-1:0] q;
	logic [BUS_AW-1:0] pa [3];
	logic [BUS_DW-1:0] pd [3];
	logic [7:0]        pv [2] = '{PROT_READ_ONLY, PROT_WRITE_ONLY};
	int                n_mismatch = 0;
	int                num_checks = 0;

	flash_auto_operation_status #(
		.MEM_AW(13),
		.SECTOR_CYC(5000),
		.CHIP_CYC(20000)
	) i_flash_auto_operation_status (
		.I_SYS_CLK(clk),
		.I_RST_N(rst_n),
		.I_SINGLE_BOOT(single_boot),
		.I_BUS_REQ(req),
		.O_BUS_RVALID(rvalid),
		.O_BUS_RDATA(rdata),
		.O_STAT(stat)
	);

	flash_cpu_model i_flash_cpu_model (.clk(clk), .req(req), .rvalid(rvalid), .rdata(rdata));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic give_verdict();
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [BUS_DW-1:0] seen, input logic [BUS_DW-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [BUS_AW-1:0] ofs(input logic [CMD_OFS_W-1:0] o);
		return {BASE[BUS_AW-1:CMD_OFS_W], o};
	endfunction

	function automatic logic [BUS_DW-1:0] poll_bits(input logic [BUS_DW-1:0] d);
		return {~d[15], 7'h0, ~d[7], 7'h0};
	endfunction

	function automatic logic [1:0] prot_exp(input logic [7:0] v);
		return {v != PROT_WRITE_ONLY, v != PROT_READ_ONLY};
	endfunction

	task automatic wr(input logic [BUS_AW-1:0] a, input logic [7:0] d);
		i_flash_cpu_model.wr(a, {8'h0, d});
	endtask

	task automatic rd(input logic [BUS_AW-1:0] a, input logic b);
		i_flash_cpu_model.rd(a, b, q);
	endtask

	task automatic unlock();
		wr(ofs(CMD_OFS_A), CMD_UNLOCK_A);
		wr(ofs(CMD_OFS_B), CMD_UNLOCK_B);
	endtask

	task automatic prog(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
		unlock();
		wr(ofs(CMD_OFS_A), CMD_PROGRAM);
		i_flash_cpu_model.wr(a, d);
	endtask

	task automatic erase(input logic [BUS_AW-1:0] a, input logic [7:0] c);
		unlock();
		wr(ofs(CMD_OFS_A), CMD_ERASE);
		unlock();
		wr(a, c);
	endtask

	// status walk, poll to the end, wait out the settle window
	task automatic track(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] m, input logic [BUS_DW-1:0] e, input int lim);
		logic [BUS_DW-1:0] t;
		repeat (2) @(posedge clk);
		check(16'(stat.busy), 16'h1);
		for (int k = 0; k < 4; k++) begin
			rd(a, 1'b0);
			t = k[0] ? 16'h0 : 16'h4040;
			check(q & m, (e | t) & m);
		end
		i_flash_cpu_model.poll(a, lim, q);
		check(16'(stat.settling), 16'h1);
		check(q & m & 16'h8080, ~e & m & 16'h8080);
		for (int k = 0; k < 40 && stat.settling !== 1'b0; k++)
			@(posedge clk);
		check(16'(stat.settling), 16'h0);
	endtask

	initial begin
		void'($urandom(32'hfc71));
		rst_n = 1'b0;
		single_boot = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		check(16'({rvalid, stat}), 16'h0);
		erase(ofs(CMD_OFS_A), CMD_CHIP);
		track(BASE, 16'hc0c0, 16'h0, 6000);
		for (int k = 0; k < 4; k++) begin
			rd(BASE + 24'($urandom_range(0, 8191) * 2), 1'b0);
			check(q, ERASED_WORD);
		end
		for (int k = 0; k < 2; k++) begin
			unlock();
			wr(ofs(CMD_OFS_A), CMD_PROTECT);
			wr(ofs(PROT_OFS), pv[k]);
			track(ofs(PROT_OFS), 16'h4040, 16'h0, 600);
			check(16'({stat.read_protect, stat.write_protect}), 16'(prot_exp(pv[k])));
			erase(ofs(CMD_OFS_A), CMD_CHIP);
			track(BASE, 16'hc0c0, 16'h0, 6000);
			check(16'({stat.read_protect, stat.write_protect}), 16'h0);
		end
		unlock();
		wr(ofs(CMD_OFS_A), 8'h77);
		wr(ofs(CMD_OFS_A), CMD_PROGRAM);
		wr(BASE + 24'h10, 8'h34);
		@(posedge clk);
		check(16'(stat.busy), 16'h0);
		rd(BASE + 24'h10, 1'b0);
		check(q, ERASED_WORD);
		for (int k = 0; k < 3; k++) begin
			pa[k] = BASE + 24'(k * 4096) + 24'($urandom_range(0, 511) * 2);
			pd[k] = 16'($urandom());
			prog(pa[k], pd[k]);
			prog(pa[k] ^ 24'h2, 16'h0);
			track(pa[k], 16'hc0c0, poll_bits(pd[k]), 600);
			rd(pa[k], 1'b0);
			check(q, pd[k]);
			rd(pa[k], 1'b1);
			check(q, {8'h0, pd[k][7:0]});
			rd(pa[k] | 24'h1, 1'b1);
			check(q, {8'h0, pd[k][15:8]});
			rd(pa[k] ^ 24'h2, 1'b0);
			check(q, ERASED_WORD);
		end
		erase(BASE + 24'h0c00, CMD_SECTOR);
		track(BASE, 16'hc0c0, 16'h0, 1500);
		rd(pa[0], 1'b0);
		check(q, ERASED_WORD);
		rd(pa[2], 1'b0);
		check(q, pd[2]);
		single_boot <= 1'b1;
		rd(24'h010000 + (pa[2] - BASE), 1'b0);
		check(q, pd[2]);
		rd(24'hff0100, 1'b0);
		check(q, 16'hxxxx);
		check(16'(i_flash_cpu_model.poll_fail), 16'h0);
		give_verdict();
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
endmodule
